// File: design/fnc_cyc_if.sv
// Single bus-cycle request channel between the sequencer and the strobe engine.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface fnc_cyc_if;
	logic req;
	logic we;
	logic [fnc_pkg::ADDR_W-1:0] addr;
	logic [fnc_pkg::DATA_W-1:0] wdata;
	logic ack;
	logic [fnc_pkg::DATA_W-1:0] rdata;
	modport master (output req, output we, output addr, output wdata, input ack, input rdata);
	modport slave (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

// File: design/fnc_cycle.sv
// Strobe engine: one flash read or write cycle per request.
// Assumes the requester holds req and its fields steady until ack.
`timescale 1ns/1ps
module fnc_cycle (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	fnc_cyc_if.slave cyc,
	output logic [fnc_pkg::ADDR_W-1:0] o_flash_addr,
	output logic o_flash_ce_n,
	output logic o_flash_we_n,
	output logic o_flash_oe_n,
	output logic [fnc_pkg::DATA_W-1:0] o_flash_dq,
	output logic o_flash_dq_oe,
	input wire logic [fnc_pkg::DATA_W-1:0] i_flash_dq
);
	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_LOW = 2'b01,
		C_HIGH = 2'b11
	} fnc_cst_t;

	fnc_cst_t st_q, st_d;
	logic [fnc_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [fnc_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [fnc_pkg::DATA_W-1:0] dq_q, dq_d, rd_q, rd_d;
	logic ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d, dq_oe_q, dq_oe_d;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		addr_d = addr_q;
		dq_d = dq_q;
		rd_d = rd_q;
		ce_n_d = ce_n_q;
		we_n_d = we_n_q;
		oe_n_d = oe_n_q;
		dq_oe_d = dq_oe_q;
		case (st_q)
			C_IDLE:
			begin
				if (cyc.req)
				begin
					addr_d = cyc.addr;
					dq_d = cyc.wdata;
					ce_n_d = 1'b0;
					we_n_d = !cyc.we;
					oe_n_d = cyc.we;
					dq_oe_d = cyc.we;
					cnt_d = cyc.we ? fnc_pkg::WP_CYC : fnc_pkg::ACC_CYC;
					st_d = C_LOW;
				end
			end
			C_LOW:
			begin
				cnt_d = cnt_q - fnc_pkg::CNT_ONE;
				if (cnt_q == fnc_pkg::CNT_ONE)
				begin
					if (!oe_n_q)
						rd_d = i_flash_dq;
					// Reads release both strobes so either edge advances the toggle
					ce_n_d = 1'b1;
					oe_n_d = 1'b1;
					we_n_d = 1'b1;
					dq_oe_d = 1'b0;
					cnt_d = fnc_pkg::OEHP_CYC;
					st_d = C_HIGH;
				end
			end
			C_HIGH:
			begin
				cnt_d = cnt_q - fnc_pkg::CNT_ONE;
				if (cnt_q == fnc_pkg::CNT_ONE)
					st_d = C_IDLE;
			end
			default:
				st_d = C_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			st_q <= C_IDLE;
			cnt_q <= '0;
			addr_q <= '0;
			dq_q <= '0;
			rd_q <= '0;
			ce_n_q <= 1'b1;
			we_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			dq_oe_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			dq_q <= dq_d;
			rd_q <= rd_d;
			ce_n_q <= ce_n_d;
			we_n_q <= we_n_d;
			oe_n_q <= oe_n_d;
			dq_oe_q <= dq_oe_d;
		end
	end

	assign cyc.ack = (st_q == C_HIGH) && (cnt_q == fnc_pkg::CNT_ONE);
	assign cyc.rdata = rd_q;
	assign o_flash_addr = addr_q;
	assign o_flash_ce_n = ce_n_q;
	assign o_flash_we_n = we_n_q;
	assign o_flash_oe_n = oe_n_q;
	assign o_flash_dq = dq_q;
	assign o_flash_dq_oe = dq_oe_q;

	oe_high_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(!o_flash_we_n && !o_flash_ce_n) |-> o_flash_oe_n)
		else $error("Output enable low during a write strobe");
	strobe_gap_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		$rose(o_flash_oe_n) |-> (o_flash_oe_n && o_flash_ce_n) [*2])
		else $error("Read strobe high time too short");
endmodule

// File: design/fnc_host.sv
// Host-side command sequencer for an asynchronous x16 NOR flash.
// Assumes one op at a time from the user port and a flash on the pins.
`timescale 1ns/1ps
module fnc_host #(
	parameter logic [fnc_pkg::TMO_W-1:0] SEC4K_TMO = fnc_pkg::SEC4K_TMO_CYC,
	parameter logic [fnc_pkg::TMO_W-1:0] SEC32K_TMO = fnc_pkg::SEC32K_TMO_CYC,
	parameter logic [fnc_pkg::TMO_W-1:0] CHIP_TMO = fnc_pkg::CHIP_TMO_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_cmd_valid,
	input wire fnc_pkg::fnc_op_t i_cmd_op,
	input wire logic [fnc_pkg::ADDR_W-1:0] i_cmd_addr,
	input wire logic [fnc_pkg::DATA_W-1:0] i_cmd_data,
	output logic o_cmd_ready,
	output logic o_done,
	output logic o_timeout,
	output logic [fnc_pkg::DATA_W-1:0] o_rdata,
	output logic [fnc_pkg::ADDR_W-1:0] o_flash_addr,
	output logic o_flash_ce_n,
	output logic o_flash_we_n,
	output logic o_flash_oe_n,
	output logic [fnc_pkg::DATA_W-1:0] o_flash_dq,
	output logic o_flash_dq_oe,
	input wire logic [fnc_pkg::DATA_W-1:0] i_flash_dq
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_STEP = 2'b01,
		S_BUS = 2'b11,
		S_DONE = 2'b10
	} fnc_st_t;

	// Command word in the low byte and low twelve address lines only
	function automatic fnc_pkg::fnc_step_t mk(fnc_pkg::fnc_kind_t k, logic u,
		logic [fnc_pkg::CMD_AW-1:0] a, logic [7:0] d);
		fnc_pkg::fnc_step_t s;
		s.kind = k;
		s.usr = u;
		s.addr = a;
		s.data = d;
		return s;
	endfunction

	function automatic fnc_pkg::fnc_step_t unlock(logic [fnc_pkg::IDX_W-1:0] i);
		return (i[0] == 1'b0) ? mk(fnc_pkg::K_WR, 1'b0, fnc_pkg::A_UNLOCK1, fnc_pkg::D_UNLOCK1)
			: mk(fnc_pkg::K_WR, 1'b0, fnc_pkg::A_UNLOCK2, fnc_pkg::D_UNLOCK2);
	endfunction

	function automatic fnc_pkg::fnc_step_t step_of(fnc_pkg::fnc_op_t op,
		logic [fnc_pkg::IDX_W-1:0] i);
		fnc_pkg::fnc_step_t s;
		s = mk(fnc_pkg::K_END, 1'b0, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
		case (op)
			fnc_pkg::OP_READ:
				if (i == 4'h0)
					s = mk(fnc_pkg::K_RD, 1'b1, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
			fnc_pkg::OP_PROG:
				case (i)
					4'h0, 4'h1: s = unlock(i);
					4'h2: s = mk(fnc_pkg::K_WR, 1'b0, fnc_pkg::A_UNLOCK1, fnc_pkg::D_PROG);
					4'h3: s = mk(fnc_pkg::K_WR, 1'b1, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
					4'h4: s = mk(fnc_pkg::K_POLL, 1'b1, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
					default: s = mk(fnc_pkg::K_END, 1'b0, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
				endcase
			fnc_pkg::OP_ERASE_4K, fnc_pkg::OP_ERASE_32K, fnc_pkg::OP_CHIP_ERASE:
				case (i)
					4'h0, 4'h1: s = unlock(i);
					4'h3, 4'h4: s = unlock(i + 4'h1);
					4'h2: s = mk(fnc_pkg::K_WR, 1'b0, fnc_pkg::A_UNLOCK1, fnc_pkg::D_ERASE);
					4'h5:
						if (op == fnc_pkg::OP_CHIP_ERASE)
							s = mk(fnc_pkg::K_WR, 1'b0, fnc_pkg::A_UNLOCK1, fnc_pkg::D_CHIP);
						else
							s = mk(fnc_pkg::K_WR, 1'b1, fnc_pkg::A_NONE, fnc_pkg::D_SECTOR);
					4'h6: s = mk(fnc_pkg::K_POLL, 1'b1, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
					default: s = mk(fnc_pkg::K_END, 1'b0, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
				endcase
			fnc_pkg::OP_ID_READ:
				case (i)
					4'h0, 4'h1: s = unlock(i);
					4'h2: s = mk(fnc_pkg::K_WR, 1'b0, fnc_pkg::A_UNLOCK1, fnc_pkg::D_ID_ENTRY);
					4'h3: s = mk(fnc_pkg::K_RD, 1'b1, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
					// Single-write exit form; device treats both forms alike
					4'h4: s = mk(fnc_pkg::K_WR, 1'b0, fnc_pkg::A_NONE, fnc_pkg::D_EXIT);
					default: s = mk(fnc_pkg::K_END, 1'b0, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
				endcase
			fnc_pkg::OP_QUERY_READ:
				case (i)
					4'h0: s = mk(fnc_pkg::K_WR, 1'b0, fnc_pkg::A_QUERY, fnc_pkg::D_QUERY);
					4'h1: s = mk(fnc_pkg::K_RD, 1'b1, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
					4'h2: s = mk(fnc_pkg::K_WR, 1'b0, fnc_pkg::A_NONE, fnc_pkg::D_EXIT);
					default: s = mk(fnc_pkg::K_END, 1'b0, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
				endcase
			default:
				s = mk(fnc_pkg::K_END, 1'b0, fnc_pkg::A_NONE, fnc_pkg::D_NONE);
		endcase
		return s;
	endfunction

	fnc_cyc_if cyc ();

	fnc_st_t st_q, st_d;
	fnc_pkg::fnc_op_t op_q, op_d;
	logic [fnc_pkg::IDX_W-1:0] idx_q, idx_d;
	logic [fnc_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [fnc_pkg::DATA_W-1:0] data_q, data_d, rdata_q, rdata_d;
	logic [fnc_pkg::TMO_W-1:0] tmo_q, tmo_d;
	logic prev_q, prev_d, havep_q, havep_d, done_q, done_d, err_q, err_d;
	fnc_pkg::fnc_step_t step;
	logic tbit;

	assign step = step_of(op_q, idx_q);
	assign tbit = cyc.rdata[fnc_pkg::TOGGLE_BIT];

	always_comb
	begin
		cyc.req = (st_q == S_BUS);
		cyc.we = (step.kind == fnc_pkg::K_WR);
		// Command cycles drive zeros on the don't-care lines
		cyc.addr = {{(fnc_pkg::ADDR_W-fnc_pkg::CMD_AW){1'b0}}, step.addr};
		cyc.wdata = {8'h00, step.data};
		if (step.usr)
		begin
			cyc.addr = addr_q;
			cyc.wdata = data_q;
			if (op_q == fnc_pkg::OP_ID_READ)
				cyc.addr = {{(fnc_pkg::ADDR_W-1){1'b0}}, addr_q[0]};
			if (op_q != fnc_pkg::OP_PROG)
				cyc.wdata = {8'h00, step.data};
		end
	end

	always_comb
	begin
		st_d = st_q;
		op_d = op_q;
		idx_d = idx_q;
		addr_d = addr_q;
		data_d = data_q;
		rdata_d = rdata_q;
		tmo_d = tmo_q;
		prev_d = prev_q;
		havep_d = havep_q;
		done_d = 1'b0;
		err_d = err_q;
		if (step.kind == fnc_pkg::K_POLL && st_q != S_IDLE && tmo_q != '0)
			tmo_d = tmo_q - fnc_pkg::TMO_ONE;
		case (st_q)
			S_IDLE:
				if (i_cmd_valid)
				begin
					op_d = i_cmd_op;
					addr_d = i_cmd_addr;
					data_d = i_cmd_data;
					idx_d = '0;
					havep_d = 1'b0;
					err_d = 1'b0;
					case (i_cmd_op)
						fnc_pkg::OP_ERASE_4K: tmo_d = SEC4K_TMO;
						fnc_pkg::OP_ERASE_32K: tmo_d = SEC32K_TMO;
						fnc_pkg::OP_CHIP_ERASE: tmo_d = CHIP_TMO;
						default: tmo_d = fnc_pkg::PROG_TMO_CYC;
					endcase
					st_d = S_STEP;
				end
			S_STEP:
				if (step.kind == fnc_pkg::K_END)
				begin
					done_d = 1'b1;
					st_d = S_DONE;
				end
				else if (step.kind == fnc_pkg::K_POLL && tmo_q == '0)
				begin
					// Timeout is taken only between cycles so no strobe is cut short
					err_d = 1'b1;
					done_d = 1'b1;
					st_d = S_DONE;
				end
				else
					st_d = S_BUS;
			S_BUS:
				if (cyc.ack)
				begin
					st_d = S_STEP;
					if (step.kind == fnc_pkg::K_POLL)
					begin
						prev_d = tbit;
						havep_d = 1'b1;
						// Bit level means nothing; only a steady bit ends busy
						if (havep_q && tbit == prev_q)
							idx_d = idx_q + 4'h1;
					end
					else
					begin
						if (step.kind == fnc_pkg::K_RD)
							rdata_d = cyc.rdata;
						idx_d = idx_q + 4'h1;
					end
				end
			S_DONE:
				st_d = S_IDLE;
			default:
				st_d = S_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			st_q <= S_IDLE;
			op_q <= fnc_pkg::OP_READ;
			idx_q <= '0;
			addr_q <= '0;
			data_q <= '0;
			rdata_q <= '0;
			tmo_q <= '0;
			prev_q <= 1'b0;
			havep_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			op_q <= op_d;
			idx_q <= idx_d;
			addr_q <= addr_d;
			data_q <= data_d;
			rdata_q <= rdata_d;
			tmo_q <= tmo_d;
			prev_q <= prev_d;
			havep_q <= havep_d;
			done_q <= done_d;
			err_q <= err_d;
		end
	end

	assign o_cmd_ready = (st_q == S_IDLE);
	assign o_done = done_q;
	assign o_timeout = err_q;
	assign o_rdata = rdata_q;

	fnc_cycle u_cycle (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.cyc(cyc.slave),
		.o_flash_addr(o_flash_addr),
		.o_flash_ce_n(o_flash_ce_n),
		.o_flash_we_n(o_flash_we_n),
		.o_flash_oe_n(o_flash_oe_n),
		.o_flash_dq(o_flash_dq),
		.o_flash_dq_oe(o_flash_dq_oe),
		.i_flash_dq(i_flash_dq)
	);

	sequence cmd_wr_s;
		cyc.req && cyc.we && !step.usr;
	endsequence
	sequence last_erase_s;
		cyc.req && cyc.we && idx_q == 4'h5 &&
			(op_q == fnc_pkg::OP_ERASE_4K || op_q == fnc_pkg::OP_ERASE_32K);
	endsequence
	sequence steady_poll_s;
		st_q == S_BUS && cyc.ack && step.kind == fnc_pkg::K_POLL && havep_q && tbit == prev_q;
	endsequence

	cmd_upper_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		cmd_wr_s |-> cyc.wdata[15:8] == 8'h00)
		else $error("Command word upper byte not zero");
	cmd_addr_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		cmd_wr_s |-> cyc.addr[fnc_pkg::ADDR_W-1:fnc_pkg::CMD_AW] == '0)
		else $error("Command address uses high lines");
	chip_last_word_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(cyc.req && cyc.we && idx_q == 4'h5 && op_q == fnc_pkg::OP_CHIP_ERASE)
			|-> cyc.addr == 22'h000555 && cyc.wdata == 16'h0010)
		else $error("Chip erase final write wrong");
	sector_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		last_erase_s |-> cyc.wdata == 16'h0030)
		else $error("Sector erase final data not 30H");
	sector_addr_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		last_erase_s |-> cyc.addr == addr_q)
		else $error("Sector erase address not the user sector");
	poll_addr_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		// Compares one poll with the next, not two cycles of the same poll
		(cyc.ack && step.kind == fnc_pkg::K_POLL) ##1 (st_q == S_STEP) ##1
			(cyc.req && step.kind == fnc_pkg::K_POLL) |-> cyc.addr == $past(cyc.addr, 2))
		else $error("Poll address moved");
	id_addr_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(cyc.req && op_q == fnc_pkg::OP_ID_READ && step.kind == fnc_pkg::K_RD)
			|-> cyc.addr[fnc_pkg::ADDR_W-1:1] == '0)
		else $error("Identification read address high lines set");
	toggle_done_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		steady_poll_s |=> ##1 o_done ##1 o_cmd_ready)
		else $error("Steady toggle bit did not end the poll");
	poll_timeout_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(st_q == S_STEP && step.kind == fnc_pkg::K_POLL && tmo_q == '0) |=> o_done && o_timeout)
		else $error("Poll timeout not reported");
endmodule

// File: design/fnc_pkg.sv
// Constants, types and timing for the NOR flash command host.
// Assumes a 25 MHz reference clock and an asynchronous x16 NOR flash.
package fnc_pkg;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int CMD_AW = 12;
	localparam int CNT_W = 3;
	localparam int TMO_W = 32;
	localparam int IDX_W = 4;
	localparam int TOGGLE_BIT = 6;
	localparam int CLK_NS = 40;
	localparam int T_WP_NS = 25;
	localparam int T_ACC_NS = 70;
	localparam int T_OEHP_NS = 50;
	localparam logic [CNT_W-1:0] WP_CYC = CNT_W'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] OEHP_CYC = CNT_W'((T_OEHP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	// Longest busy times; program limits stay below the parameter threshold
	localparam int T_PROG_MAX_US = 120;
	localparam int T_PROG_DUAL_MAX_US = 60;
	localparam int T_SEC4K_MAX_MS = 2000;
	localparam int T_SEC32K_MAX_MS = 6000;
	localparam int T_CHIP_S = 64;
	localparam logic [TMO_W-1:0] PROG_TMO_CYC = TMO_W'(T_PROG_MAX_US * 1000 / CLK_NS);
	localparam logic [TMO_W-1:0] SEC4K_TMO_CYC = TMO_W'(T_SEC4K_MAX_MS * (1000000 / CLK_NS));
	localparam logic [TMO_W-1:0] SEC32K_TMO_CYC = TMO_W'(T_SEC32K_MAX_MS * (1000000 / CLK_NS));
	localparam logic [TMO_W-1:0] CHIP_TMO_CYC = TMO_W'(T_CHIP_S * (1000000000 / CLK_NS));
	localparam logic [TMO_W-1:0] TMO_ONE = TMO_W'(1);
	localparam logic [CMD_AW-1:0] A_UNLOCK1 = 12'h555;
	localparam logic [CMD_AW-1:0] A_UNLOCK2 = 12'h2AA;
	localparam logic [CMD_AW-1:0] A_QUERY = 12'h055;
	localparam logic [CMD_AW-1:0] A_NONE = 12'h000;
	localparam logic [7:0] D_UNLOCK1 = 8'hAA;
	localparam logic [7:0] D_UNLOCK2 = 8'h55;
	localparam logic [7:0] D_PROG = 8'hA0;
	localparam logic [7:0] D_ERASE = 8'h80;
	localparam logic [7:0] D_CHIP = 8'h10;
	localparam logic [7:0] D_SECTOR = 8'h30;
	localparam logic [7:0] D_ID_ENTRY = 8'h90;
	localparam logic [7:0] D_QUERY = 8'h98;
	localparam logic [7:0] D_EXIT = 8'hF0;
	localparam logic [7:0] D_NONE = 8'h00;
	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROG = 3'h1,
		OP_ERASE_4K = 3'h2,
		OP_ERASE_32K = 3'h3,
		OP_CHIP_ERASE = 3'h4,
		OP_ID_READ = 3'h5,
		OP_QUERY_READ = 3'h6
	} fnc_op_t;
	typedef enum logic [1:0] {
		K_WR = 2'h0,
		K_RD = 2'h1,
		K_POLL = 2'h2,
		K_END = 2'h3
	} fnc_kind_t;
	typedef struct packed {
		fnc_kind_t kind;
		logic usr;
		logic [CMD_AW-1:0] addr;
		logic [7:0] data;
	} fnc_step_t;
endpackage

// File: sim/fnc_flash_model.sv
// Behavioural x16 NOR flash that answers the host strobes on the pins.
// Assumes the bench sets how many polls an operation stays busy.
`timescale 1ns/1ps
module fnc_flash_model #(
	parameter logic [15:0] MAKER = 16'h00A1, // Arbitrary value
	parameter logic [15:0] DEVICE = 16'h00B2 // Arbitrary value
) (
	input wire logic [21:0] i_addr,
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [15:0] i_dq,
	input wire logic [15:0] i_busy_polls,
	output logic [15:0] o_dq,
	output logic [7:0] o_viol
);
	logic [15:0] mem [int];
	logic [15:0] cur = 16'h0000;
	logic [15:0] last = 16'h0000;
	logic [21:0] poll_a = 22'h000000;
	logic pset = 1'b0;
	logic tog = 1'b0;
	int st = 0;
	int mode = 0; // Array read at power-up
	int busy = 0;
	realtime rd_end = 0.0;
	logic [21:0] wa = 22'h000000;
	logic [15:0] wd = 16'h0000;
	wire wr_act = !i_ce_n && !i_we_n;
	wire rd_act = !i_ce_n && !i_oe_n;
	wire oe_clash = wr_act && !i_oe_n;
	// Released bus shows the inverted last word so a late sample cannot pass by luck
	assign o_dq = rd_act ? cur : ~last;
	initial o_viol = 8'h00;
	function automatic logic [15:0] word(input int a);
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction
	function automatic logic [15:0] query(input logic [7:0] a);
		case (a)
			8'h10: return 16'h0051;
			8'h11: return 16'h0052;
			8'h12: return 16'h0059;
			8'h1F: return 16'h0004;
			8'h21: return 16'h0009;
			8'h22: return 16'h0010;
			8'h23, 8'h24, 8'h25, 8'h26: return 16'h0004;
			8'h2A: return 16'h0002;
			default: return 16'h0000;
		endcase
	endfunction
	// Busy length stands in for program and erase times
	task automatic go();
		busy = int'(i_busy_polls);
		pset = 1'b0;
	endtask
	always @(posedge oe_clash) o_viol = o_viol + 8'h01;
	// Write word taken just after the strobe falls; host may drop its drive as the strobe rises
	always @(posedge wr_act)
	begin
		#1;
		wa = i_addr;
		wd = i_dq;
	end
	always @(posedge rd_act)
	begin
		if ($realtime - rd_end < 50.0)
			o_viol = o_viol + 8'h01;
		#1;
		if (busy > 0)
		begin
			if (pset && poll_a !== i_addr)
				o_viol = o_viol + 8'h01;
			poll_a = i_addr;
			pset = 1'b1;
			cur = {9'h000, tog, 6'h00};
		end
		else if (mode == 1)
			cur = (i_addr[21:1] == 21'h0) ? (i_addr[0] ? DEVICE : MAKER) : 16'h0000;
		else if (mode == 2)
			cur = query(i_addr[7:0]);
		else
			cur = word(i_addr);
	end
	always @(negedge rd_act)
	begin
		last = cur;
		rd_end = $realtime;
		if (busy > 0)
		begin
			tog = !tog;
			busy = busy - 1;
		end
	end
	always @(negedge wr_act)
	begin
		logic [11:0] a;
		logic [7:0] d;
		int q[$];
		int sz;
		q.delete();
		// Only the low byte and low twelve address lines decode
		a = wa[11:0];
		d = wd[7:0];
		if (st == 3)
		begin
			mem[wa] = word(wa) & wd;
			go();
		end
		else if (d == 8'hF0)
			mode = 0;
		else if (a == 12'h055 && d == 8'h98)
			mode = 2;
		else if (st == 2 && a == 12'h555 && d == 8'h90)
			mode = 1;
		else if (st == 6 && d == 8'h10)
		begin
			if (a != 12'h555)
				o_viol = o_viol + 8'h01;
			mem.delete();
			go();
		end
		else if (st == 6 && d == 8'h30)
		begin
			sz = (wa < 22'h008000) ? 32'h1000 : 32'h8000;
			foreach (mem[k])
				if (k / sz == wa / sz)
					q.push_back(k);
			foreach (q[i])
				mem.delete(q[i]);
			go();
		end
		case (st)
			0: st = (a == 12'h555 && d == 8'hAA) ? 1 : 0;
			1: st = (a == 12'h2AA && d == 8'h55) ? 2 : 0;
			2: st = (a != 12'h555) ? 0 : (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
			4: st = (a == 12'h555 && d == 8'hAA) ? 5 : 0;
			5: st = (a == 12'h2AA && d == 8'h55) ? 6 : 0;
			default: st = 0;
		endcase
	end
endmodule

// File: sim/fnc_host_bench.sv
// Self-checking bench for the NOR flash command host.
// Assumes the behavioural flash model on the pins and short erase timeouts.
`timescale 1ns/1ps
module fnc_host_bench;
	localparam logic [15:0] MAKER = 16'h00A1; // Arbitrary value
	localparam logic [15:0] DEVICE = 16'h00B2; // Arbitrary value
	logic i_ref_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_cmd_valid = 1'b0;
	fnc_pkg::fnc_op_t i_cmd_op = fnc_pkg::OP_READ;
	logic [21:0] i_cmd_addr = 22'h000000;
	logic [15:0] i_cmd_data = 16'h0000;
	logic [15:0] busy_polls = 16'h0004;
	logic o_cmd_ready, o_done, o_timeout, o_flash_ce_n, o_flash_we_n, o_flash_oe_n, o_flash_dq_oe;
	logic [15:0] o_rdata, o_flash_dq, f_dq;
	logic [21:0] o_flash_addr;
	logic [7:0] viol;
	wire [15:0] dq_bus = o_flash_dq_oe ? o_flash_dq : f_dq;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	fnc_host #(.SEC4K_TMO(32'hC8), .SEC32K_TMO(32'hC8), .CHIP_TMO(32'hC8)) dut (
		.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
		.i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data),
		.o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_timeout(o_timeout), .o_rdata(o_rdata),
		.o_flash_addr(o_flash_addr), .o_flash_ce_n(o_flash_ce_n), .o_flash_we_n(o_flash_we_n),
		.o_flash_oe_n(o_flash_oe_n), .o_flash_dq(o_flash_dq), .o_flash_dq_oe(o_flash_dq_oe),
		.i_flash_dq(dq_bus));
	fnc_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) flash (
		.i_addr(o_flash_addr), .i_ce_n(o_flash_ce_n), .i_we_n(o_flash_we_n),
		.i_oe_n(o_flash_oe_n), .i_dq(dq_bus), .i_busy_polls(busy_polls), .o_dq(f_dq),
		.o_viol(viol));
	initial forever #20 i_ref_clk = ~i_ref_clk;
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// One op through the user port; ready is high in idle so the next edge takes it
	task automatic run(input fnc_pkg::fnc_op_t op, input logic [21:0] a, input logic [15:0] d,
		output logic [15:0] rd, output logic to);
		int n;
		n = 0;
		@(posedge i_ref_clk);
		i_cmd_op <= op;
		i_cmd_addr <= a;
		i_cmd_data <= d;
		i_cmd_valid <= 1'b1;
		@(posedge i_ref_clk);
		i_cmd_valid <= 1'b0;
		while (o_done !== 1'b1 && n < 4000)
		begin
			@(posedge i_ref_clk);
			n++;
		end
		if (n >= 4000)
			chk(16'h0000, 16'h0001, "op never done");
		rd = o_rdata;
		to = o_timeout;
	endtask
	task automatic rdchk(input logic [21:0] a, input logic [15:0] exp, input string what);
		logic [15:0] rd;
		logic to;
		run(fnc_pkg::OP_READ, a, 16'h0000, rd, to);
		chk(rd, exp, what);
	endtask
	task automatic opchk(input fnc_pkg::fnc_op_t op, input logic [21:0] a, input logic [15:0] d,
		input logic to_exp);
		logic [15:0] rd;
		logic to;
		run(op, a, d, rd, to);
		chk({15'h0000, to}, {15'h0000, to_exp}, "timeout flag");
	endtask
	task automatic t_reset();
		chk({11'h000, o_flash_ce_n, o_flash_we_n, o_flash_oe_n, o_flash_dq_oe, o_cmd_ready},
			16'h001D, "idle pins");
		chk({o_rdata[13:0], o_done, o_timeout}, 16'h0000, "idle outputs");
	endtask
	task automatic t_prog();
		busy_polls <= 16'h0005;
		opchk(fnc_pkg::OP_PROG, 22'h012345, 16'hA5C3, 1'b0);
		opchk(fnc_pkg::OP_PROG, 22'h012346, 16'h5A3C, 1'b0);
		rdchk(22'h012345, 16'hA5C3, "program readback");
		rdchk(22'h012346, 16'h5A3C, "second word");
	endtask
	task automatic t_id();
		logic [15:0] rd;
		logic to;
		run(fnc_pkg::OP_ID_READ, 22'h000000, 16'h0000, rd, to);
		chk(rd, MAKER, "maker code");
		run(fnc_pkg::OP_ID_READ, 22'h3FF001, 16'h0000, rd, to);
		chk(rd, DEVICE, "device code");
		rdchk(22'h012345, 16'hA5C3, "array after exit");
	endtask
	task automatic t_query();
		logic [15:0] rd;
		logic to;
		logic [7:0] qa [12] = '{8'h10, 8'h11, 8'h12, 8'h1F, 8'h21, 8'h22, 8'h23, 8'h24,
			8'h25, 8'h26, 8'h2A, 8'h2B};
		logic [15:0] qd [12] = '{16'h0051, 16'h0052, 16'h0059, 16'h0004, 16'h0009, 16'h0010,
			16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0002, 16'h0000};
		for (int i = 0; i < 12; i++)
		begin
			run(fnc_pkg::OP_QUERY_READ, {14'h0000, qa[i]}, 16'h0000, rd, to);
			chk(rd, qd[i], "query word");
		end
		rdchk(22'h012346, 16'h5A3C, "array after query");
	endtask
	task automatic t_erase();
		// Prompt answers while loading, slow ones during the erases
		busy_polls <= 16'h0000;
		opchk(fnc_pkg::OP_PROG, 22'h001010, 16'h1111, 1'b0);
		opchk(fnc_pkg::OP_PROG, 22'h020000, 16'h2222, 1'b0);
		opchk(fnc_pkg::OP_PROG, 22'h028000, 16'h3333, 1'b0);
		busy_polls <= 16'h0004;
		opchk(fnc_pkg::OP_ERASE_4K, 22'h001000, 16'h0000, 1'b0);
		rdchk(22'h001010, 16'hFFFF, "small sector erased");
		rdchk(22'h020000, 16'h2222, "other sector kept");
		opchk(fnc_pkg::OP_ERASE_32K, 22'h020000, 16'h0000, 1'b0);
		rdchk(22'h020000, 16'hFFFF, "large sector erased");
		rdchk(22'h028000, 16'h3333, "next sector kept");
		opchk(fnc_pkg::OP_CHIP_ERASE, 22'h028000, 16'h0000, 1'b0);
		rdchk(22'h028000, 16'hFFFF, "chip erased");
		rdchk(22'h012345, 16'hFFFF, "chip erased far");
	endtask
	task automatic t_tmo();
		// Far more polls than the shortened limit allows
		busy_polls <= 16'h0100;
		opchk(fnc_pkg::OP_ERASE_4K, 22'h002000, 16'h0000, 1'b1);
	endtask
	always @(posedge i_ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			chk(16'h0000, 16'h0001, "run did not finish");
			finish_test();
		end
	end
	initial
	begin
		repeat (8) @(posedge i_ref_clk);
		t_reset();
		i_resetn <= 1'b1;
		t_prog();
		t_id();
		t_query();
		t_erase();
		t_tmo();
		chk({8'h00, viol}, 16'h0000, "flash pin protocol");
		finish_test();
	end
endmodule
